// File: msc_sequencer.v
`timescale 1ns/10ps
`include "msc_defines.vh"

// Notes on behaviour
// R01: low three result bits in status refresh at every conversion end.
// R02: integrating flag high exactly while the integrate phase runs.
// R03: with conversion done, idle in zero integrate, sequence count 0000.
// R04: conversion spans 2048 counts; done set at 0000, cleared at 0001.
// R05: results latched during a select-low read flag collision at strobe rise.
// R06: reading the status register clears the collision flag.
// R07: host checks collision before and after reading both result registers.
// R08: no collision when reading completes before the next conversion.
// R09: integrate phase starts and stops at fixed preset counts.
// R10: deintegration starts at set counts, ends on comparator zero crossing.
// R11: results counter counts up or down with deintegration polarity.
// R12: steps of 512, 64, 8 and 1 in the four deintegrations.
// R13: results counter copied into results register at conversion end.
// R14: results saturate at plus or minus 350440 counts.
// R15: host picks its soft overrange below 279040 raw counts.
// R16: integrate lasts 545 counts at 60 Hz, 655 counts at 50 Hz.
// R17: first deintegration polarity from integrator sign at integrate end.
// R18: after first deintegration a rest phase grounds both analog inputs.
// R19: polarity sampled again before each later deintegration.
// R20: rest follows each deintegration that crosses zero, until that phase's maximum count.
// R21: after zero crossing, deintegration continues until the next edge.
// R22: three residue cycles of times-eight then deintegration.
// R23: start adds 111 zero-integrate clocks at 60 Hz, 1 at 50 Hz; post zero integrate runs until the wrap.
// R24: accepted start request bit clears after 5 clocks.
// R25: results counter cleared when each conversion begins.
module msc_sequencer #(
  parameter SEQ_W = `MSC_SEQ_W,
  parameter PH_W = `MSC_PH_W,
  parameter RES_W = `MSC_RES_W
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [11:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire hreadyout_o,
  output wire hresp_o,
  output wire [31:0] hrdata_o,
  // analog side
  input wire comp_i,
  input wire sel_n_i,
  output wire zero_int_o,
  output wire integ_o,
  output wire deint_pos_o,
  output wire deint_neg_o,
  output wire rest_o,
  output wire times_eight_phase_o,
  output wire eoc_o
);
  // one-hot phase codes
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_PRE = 7'h02;
  localparam [6:0] S_INT = 7'h04;
  localparam [6:0] S_DEI = 7'h08;
  localparam [6:0] S_REST = 7'h10;
  localparam [6:0] S_TIMES8 = 7'h20;
  localparam [6:0] S_POST = 7'h40;

  reg [6:0] state_ff;
  reg [6:0] nxt_state;
  reg [SEQ_W-1:0] seq_ff;
  reg [SEQ_W-1:0] nxt_seq;
  reg [PH_W-1:0] ph_ff;
  reg [PH_W-1:0] nxt_ph;
  reg [1:0] dei_idx_ff;
  reg [1:0] nxt_dei_idx;
  reg up_ff;
  reg nxt_up;
  reg [RES_W-1:0] acc_ff;
  reg [RES_W-1:0] nxt_acc;
  reg [RES_W-1:0] result_ff;
  reg latch_evt;
  reg accept_evt;
  reg start_ff;
  reg mode50_ff;
  reg [2:0] hold_ff;
  reg hold_on_ff;
  reg pend_ff;
  reg coll_ff;
  reg sel_prev_ff;
  reg integ_ff;
  reg zero_int_ff;
  reg dpos_ff;
  reg dneg_ff;
  reg rest_ff;
  reg times8_ff;
  reg eoc_ff;
  reg dp_wr_ff;
  reg [11:0] dp_addr_ff;
  reg [31:0] rdata_ff;
  reg hreadyout_ff;
  reg [31:0] nxt_rdata;
  reg st_rd;
  wire [1:0] pins_lvl;
  wire comp_lvl;
  wire sel_lvl;
  wire addr_ok;
  wire crossing;
  wire [PH_W-1:0] dei_max;

  // step weight of a deintegration index
  function [RES_W-1:0] step_of;
    input [1:0] idx;
    begin
      if (idx == 2'h0) begin
        step_of = `MSC_STEP1;
      end else if (idx == 2'h1) begin
        step_of = `MSC_STEP2;
      end else if (idx == 2'h2) begin
        step_of = `MSC_STEP3;
      end else begin
        step_of = `MSC_STEP4;
      end
    end
  endfunction

  // signed add of a step, clamped to the hard limit
  function [RES_W-1:0] sat_step;
    input [RES_W-1:0] a;
    input [RES_W-1:0] s;
    input up;
    reg [RES_W-1:0] sum;
    begin
      sum = up ? (a + s) : (a - s);
      if (up && !sum[RES_W-1] && (sum > `MSC_RES_LIMIT)) begin
        sat_step = `MSC_RES_LIMIT;
      end else if (!up && sum[RES_W-1] && ((~sum + 1'b1) > `MSC_RES_LIMIT))
      begin
        sat_step = ~`MSC_RES_LIMIT + 1'b1;
      end else begin
        sat_step = sum;
      end
    end
  endfunction

  // comparator and select strobe from the pins
  msc_pin_sync #(
    .W(2),
    .INIT(2'b10)
  ) u_pins (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({sel_n_i, comp_i}),
    .level_o(pins_lvl)
  );
  assign comp_lvl = pins_lvl[0];
  assign sel_lvl = pins_lvl[1];

  // zero crossing: comparator left the sampled sign
  assign crossing = (comp_lvl != up_ff); // [R10]
  assign dei_max = (dei_idx_ff == 2'h0) ? `MSC_DEI1_MAX : `MSC_DEIN_MAX;

  // phase sequencing
  always @* begin
    nxt_state = state_ff;
    nxt_seq = seq_ff;
    nxt_ph = ph_ff + 1'b1;
    nxt_dei_idx = dei_idx_ff;
    nxt_up = up_ff;
    nxt_acc = acc_ff;
    latch_evt = 1'b0;
    accept_evt = 1'b0;
    if (state_ff != S_IDLE) begin
      nxt_seq = seq_ff + 1'b1;
    end
    case (state_ff)
      S_IDLE: begin
        nxt_seq = `MSC_SEQ_ZERO; // [R03]
        nxt_ph = {PH_W{1'b0}};
        if (start_ff && !hold_on_ff) begin
          accept_evt = 1'b1;
          nxt_seq = `MSC_SEQ_FIRST; // [R04]
          nxt_state = S_PRE;
          nxt_acc = {RES_W{1'b0}}; // [R25]
          nxt_dei_idx = 2'h0;
        end
      end
      S_PRE: begin
        if (ph_ff == (mode50_ff ? `MSC_PRE50 : `MSC_PRE60) - 1'b1) begin
          nxt_state = S_INT; // [R23]
          nxt_ph = {PH_W{1'b0}};
        end
      end
      S_INT: begin
        if (ph_ff == (mode50_ff ? `MSC_INT50 : `MSC_INT60) - 1'b1) begin
          nxt_state = S_DEI; // [R09] [R16]
          nxt_ph = {PH_W{1'b0}};
          nxt_up = comp_lvl; // [R17]
        end
      end
      S_DEI: begin
        // count this clock even when the crossing is seen
        nxt_acc = sat_step(acc_ff, step_of(dei_idx_ff), up_ff); // [R11] [R12] [R14] [R21]
        if (crossing) begin
          nxt_state = S_REST; // [R18] [R20]
        end
        if (ph_ff == dei_max - 1'b1) begin
          nxt_state = (dei_idx_ff == `MSC_LAST_DEI) ? S_POST : S_TIMES8;
          nxt_ph = {PH_W{1'b0}};
        end
      end
      S_REST: begin
        if (ph_ff == dei_max - 1'b1) begin
          nxt_state = (dei_idx_ff == `MSC_LAST_DEI) ? S_POST : S_TIMES8; // [R22]
          nxt_ph = {PH_W{1'b0}};
        end
      end
      S_TIMES8: begin
        if (ph_ff == `MSC_TIMES8_LEN - 1'b1) begin
          nxt_state = S_DEI; // [R22]
          nxt_ph = {PH_W{1'b0}};
          nxt_dei_idx = dei_idx_ff + 1'b1;
          nxt_up = comp_lvl; // [R19]
        end
      end
      S_POST: begin
        if (ph_ff == `MSC_POST_LEN) begin
          nxt_ph = ph_ff; // [R23]
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    // wrap of the 2048-count cycle ends the conversion
    if (state_ff != S_IDLE && seq_ff == `MSC_SEQ_LAST) begin
      nxt_state = S_IDLE; // [R04]
      nxt_seq = `MSC_SEQ_ZERO;
      latch_evt = 1'b1;
    end
  end

  // phase registers and switch commands
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= S_IDLE;
      seq_ff <= `MSC_SEQ_ZERO;
      ph_ff <= {PH_W{1'b0}};
      dei_idx_ff <= 2'h0;
      up_ff <= 1'b0;
      acc_ff <= {RES_W{1'b0}};
      result_ff <= {RES_W{1'b0}};
      zero_int_ff <= 1'b1;
      integ_ff <= 1'b0;
      dpos_ff <= 1'b0;
      dneg_ff <= 1'b0;
      rest_ff <= 1'b0;
      times8_ff <= 1'b0;
      eoc_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      seq_ff <= nxt_seq;
      ph_ff <= nxt_ph;
      dei_idx_ff <= nxt_dei_idx;
      up_ff <= nxt_up;
      acc_ff <= nxt_acc;
      if (latch_evt) begin
        result_ff <= acc_ff; // [R13] [R01]
      end
      zero_int_ff <= (nxt_state == S_IDLE) || (nxt_state == S_PRE) ||
        (nxt_state == S_POST);
      integ_ff <= (nxt_state == S_INT); // [R02]
      dpos_ff <= (nxt_state == S_DEI) && nxt_up;
      dneg_ff <= (nxt_state == S_DEI) && !nxt_up;
      rest_ff <= (nxt_state == S_REST); // [R18]
      times8_ff <= (nxt_state == S_TIMES8);
      eoc_ff <= (nxt_seq == `MSC_SEQ_ZERO); // [R04] [R03]
    end
  end

  // ahb address decode
  assign addr_ok = (haddr_i == `MSC_OFS_CTRL) ||
    (haddr_i == `MSC_OFS_STATUS) || (haddr_i == `MSC_OFS_RES_LO) ||
    (haddr_i == `MSC_OFS_RES_HI);

  // read data prepared in the address phase
  always @* begin
    nxt_rdata = 32'h00000000;
    st_rd = 1'b0;
    if (hsel_i && hready_i && !hwrite_i && htrans_i[1]) begin
      if (haddr_i == `MSC_OFS_CTRL) begin
        nxt_rdata[`MSC_CTRL_START] = start_ff;
        nxt_rdata[`MSC_CTRL_MODE50] = mode50_ff;
      end else if (haddr_i == `MSC_OFS_STATUS) begin
        st_rd = 1'b1;
        nxt_rdata[`MSC_ST_LOW_MSB:`MSC_ST_LOW_LSB] =
          result_ff[`MSC_ST_LOW_MSB:`MSC_ST_LOW_LSB]; // [R01]
        nxt_rdata[`MSC_ST_NEG] = result_ff[RES_W-1];
        nxt_rdata[`MSC_ST_INTEG] = integ_ff; // [R02]
        nxt_rdata[`MSC_ST_EOC] = eoc_ff;
        nxt_rdata[`MSC_ST_COLL] = coll_ff;
      end else if (haddr_i == `MSC_OFS_RES_LO) begin
        nxt_rdata[7:0] = result_ff[`MSC_RES_LO_MSB:`MSC_RES_LO_LSB];
      end else if (haddr_i == `MSC_OFS_RES_HI) begin
        nxt_rdata[7:0] = result_ff[`MSC_RES_HI_MSB:`MSC_RES_HI_LSB];
      end else begin
        nxt_rdata = 32'h00000000;
      end
    end
  end

  // bus slave, control bits and start hold
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= 12'h000;
      rdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      start_ff <= 1'b0;
      mode50_ff <= 1'b0;
      hold_ff <= 3'h0;
      hold_on_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      dp_wr_ff <= hsel_i && hready_i && hwrite_i && htrans_i[1] && addr_ok;
      dp_addr_ff <= haddr_i;
      if (dp_wr_ff && dp_addr_ff == `MSC_OFS_CTRL) begin
        start_ff <= hwdata_i[`MSC_CTRL_START];
        mode50_ff <= hwdata_i[`MSC_CTRL_MODE50];
      end
      // accepted start stays visible then drops after the hold
      if (accept_evt) begin
        hold_on_ff <= 1'b1;
        hold_ff <= 3'h1;
      end else if (hold_on_ff) begin
        if (hold_ff == `MSC_START_HOLD) begin
          hold_on_ff <= 1'b0;
          hold_ff <= 3'h0;
          start_ff <= 1'b0; // [R24]
        end else begin
          hold_ff <= hold_ff + 1'b1;
        end
      end
    end
  end

  // collision tracking against the select strobe
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pend_ff <= 1'b0;
      coll_ff <= 1'b0;
      sel_prev_ff <= 1'b1;
    end else begin
      sel_prev_ff <= sel_lvl;
      // latch while no read is open leaves nothing pending
      if (latch_evt && !sel_lvl) begin
        pend_ff <= 1'b1; // [R05] [R08]
      end else if (sel_lvl && !sel_prev_ff) begin
        pend_ff <= 1'b0;
      end
      // set wins over the clear by a status read
      if (sel_lvl && !sel_prev_ff && pend_ff) begin
        coll_ff <= 1'b1; // [R05]
      end else if (st_rd) begin
        coll_ff <= 1'b0; // [R06]
      end
    end
  end

  assign hreadyout_o = hreadyout_ff;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_ff;
  assign zero_int_o = zero_int_ff;
  assign integ_o = integ_ff;
  assign deint_pos_o = dpos_ff;
  assign deint_neg_o = dneg_ff;
  assign rest_o = rest_ff;
  assign times_eight_phase_o = times8_ff;
  assign eoc_o = eoc_ff;
endmodule // msc_sequencer

// File: msc_defines.vh
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

// register byte offsets
`define MSC_OFS_CTRL 12'h000
`define MSC_OFS_STATUS 12'h004
`define MSC_OFS_RES_LO 12'h008
`define MSC_OFS_RES_HI 12'h00C

// control register fields
`define MSC_CTRL_START 0
`define MSC_CTRL_MODE50 1

// status register fields
`define MSC_ST_LOW_LSB 0
`define MSC_ST_LOW_MSB 2
`define MSC_ST_NEG 3
`define MSC_ST_INTEG 5
`define MSC_ST_EOC 6
`define MSC_ST_COLL 7

// result field positions
`define MSC_RES_LO_LSB 3
`define MSC_RES_LO_MSB 10
`define MSC_RES_HI_LSB 11
`define MSC_RES_HI_MSB 18

// sequence timing in clocks
`define MSC_SEQ_W 11
`define MSC_SEQ_LAST 11'h7FF
`define MSC_SEQ_FIRST 11'h001
`define MSC_SEQ_ZERO 11'h000
`define MSC_PH_W 10
`define MSC_PRE60 10'h06F
`define MSC_PRE50 10'h001
`define MSC_INT60 10'h221
`define MSC_INT50 10'h28F
`define MSC_DEI1_MAX 10'h2BC
`define MSC_DEIN_MAX 10'h020
`define MSC_TIMES8_LEN 10'h008
`define MSC_POST_LEN 10'h014
`define MSC_START_HOLD 3'h5

// results arithmetic
`define MSC_RES_W 21
`define MSC_RES_LIMIT 21'h0558E8
`define MSC_STEP1 21'h000200
`define MSC_STEP2 21'h000040
`define MSC_STEP3 21'h000008
`define MSC_STEP4 21'h000001
`define MSC_LAST_DEI 2'h3

// ahb codes
`define MSC_HTRANS_NONSEQ 2'h2
`define MSC_HTRANS_SEQ 2'h3

`endif

// File: msc_pin_sync.v
`timescale 1ns/10ps
// three-stage sampler; output moves only when stages two and three agree
module msc_pin_sync #(
  parameter W = 2,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [W-1:0] pin_i,
  output wire [W-1:0] level_o
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  reg [W-1:0] lvl_ff;
  integer i;

  // sampling chain and agreement filter
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      lvl_ff <= INIT;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign level_o = lvl_ff;
endmodule // msc_pin_sync

// File: msc_sequencer_properties.sv
`timescale 1ns/10ps
// watches phase outputs and bus response of the sequencer
module msc_sequencer_properties (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire zero_int_o,
  input wire integ_o,
  input wire deint_pos_o,
  input wire deint_neg_o,
  input wire rest_o,
  input wire times_eight_phase_o,
  input wire eoc_o
);
  logic [11:0] int_len_ff;
  logic [11:0] busy_len_ff;
  logic [2:0] times8_num_ff;

  // run length of integrate and busy, times-eight phases per conversion
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      int_len_ff <= 12'h000;
      busy_len_ff <= 12'h000;
      times8_num_ff <= 3'h0;
    end else begin
      int_len_ff <= integ_o ? int_len_ff + 12'h001 : 12'h000;
      busy_len_ff <= eoc_o ? 12'h000 : busy_len_ff + 12'h001;
      if (eoc_o) begin
        times8_num_ff <= 3'h0;
      end else if ($rose(times_eight_phase_o)) begin
        times8_num_ff <= times8_num_ff + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // integrate end must hand over to a deintegration
  sequence s_int_end;
    $fell(integ_o);
  endsequence
  sequence s_deint_go;
    ##[0:2] (deint_pos_o || deint_neg_o);
  endsequence

  a_integ_span: assert property ($fell(integ_o) |->
    (int_len_ff == 12'h221 || int_len_ff == 12'h28F))
    else $error("integrate length wrong");
  a_busy_span: assert property ($rose(eoc_o) |->
    busy_len_ff == 12'h7FF)
    else $error("conversion length wrong");
  a_idle_zero: assert property (eoc_o |-> zero_int_o && !(integ_o ||
    deint_pos_o || deint_neg_o || rest_o || times_eight_phase_o))
    else $error("idle not in zero integrate");
  a_integ_alone: assert property (integ_o |-> !eoc_o && !zero_int_o &&
    !deint_pos_o && !deint_neg_o && !rest_o)
    else $error("integrate overlaps other phase");
  a_deint_follow: assert property (s_int_end |-> s_deint_go)
    else $error("no deintegration after integrate");
  a_deint_one_way: assert property (!(deint_pos_o && deint_neg_o) &&
    !(rest_o && (deint_pos_o || deint_neg_o)))
    else $error("deintegration phases overlap");
  a_times8_length: assert property ($rose(times_eight_phase_o) |->
    times_eight_phase_o [*8] ##1 !times_eight_phase_o)
    else $error("times-eight phase length wrong");
  a_times8_count: assert property ($rose(eoc_o) |-> times8_num_ff == 3'h3)
    else $error("times-eight phase count wrong");
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus response not okay");
endmodule // msc_sequencer_properties

// File: msc_front_model.sv
`timescale 1ns/10ps
// integrator and comparator stand-in steered by the phase switches
module msc_front_model (
  input wire clk_sys_i,
  input wire signed [31:0] vin_i,
  input wire zero_i,
  input wire integ_i,
  input wire pos_i,
  input wire neg_i,
  input wire times8_i,
  output wire comp_o
);
  localparam longint REF = 1090;
  longint v_ff = 0;
  bit times8_ff = 1'b0;

  assign comp_o = (v_ff > 0); // high while integrator is positive

  // integrate input, ramp toward zero, amplify residue once per phase
  always @(posedge clk_sys_i) begin
    times8_ff <= times8_i;
    if (zero_i) begin
      v_ff <= 0;
    end else if (integ_i) begin
      v_ff <= v_ff + vin_i;
    end else if (pos_i) begin
      v_ff <= v_ff - REF;
    end else if (neg_i) begin
      v_ff <= v_ff + REF;
    end else if (times8_i && !times8_ff) begin
      v_ff <= v_ff * 8;
    end
  end
endmodule // msc_front_model

// File: msc_sequencer_bench.sv
`timescale 1ns/10ps
`include "msc_defines.vh"
module msc_sequencer_bench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [11:0] haddr_i = 12'h000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic sel_n_i = 1'b1;
  logic signed [31:0] vin = 32'sh0;
  wire hreadyout_o, hresp_o, comp_i, zero_int_o, integ_o, eoc_o;
  wire deint_pos_o, deint_neg_o, rest_o, times_eight_phase_o;
  wire [31:0] hrdata_o;
  integer fails = 0;
  integer checked = 0;
  logic [31:0] r;

  initial forever #4 clk_sys_i = ~clk_sys_i;

  msc_sequencer i_msc_sequencer (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .comp_i(comp_i), .sel_n_i(sel_n_i), .zero_int_o(zero_int_o),
    .integ_o(integ_o), .deint_pos_o(deint_pos_o),
    .deint_neg_o(deint_neg_o), .rest_o(rest_o),
    .times_eight_phase_o(times_eight_phase_o), .eoc_o(eoc_o));

  msc_front_model i_msc_front_model (.clk_sys_i(clk_sys_i), .vin_i(vin),
    .zero_i(zero_int_o), .integ_i(integ_o), .pos_i(deint_pos_o),
    .neg_i(deint_neg_o), .times8_i(times_eight_phase_o), .comp_o(comp_i));

  task close_out;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask

  // bounded wait for hready at a rising edge
  task rdy;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      if (hreadyout_o === 1'b1) return;
    end
    fails++;
    close_out();
  endtask

  // one single word transfer, read data left in r
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= `MSC_HTRANS_NONSEQ;
    hwrite_i <= w;
    rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rdy();
    r = hrdata_o;
  endtask

  // start, count integrate clocks, optional strobe mid-run or across end
  task conv(input logic m50, input logic signed [31:0] v, input logic pls,
            input logic hold, input logic [11:0] ei);
    integer n;
    n = 0;
    vin <= v;
    bus(1'b1, `MSC_OFS_CTRL, {30'h0, m50, 1'b1});
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk_sys_i);
      if (integ_o === 1'b1) n++;
      if (pls && i == 1000) sel_n_i <= 1'b0;
      if (i == 1010) sel_n_i <= 1'b1;
      if (hold && i == 2000) sel_n_i <= 1'b0;
      if (i > 20 && eoc_o === 1'b1) break;
    end
    if (eoc_o !== 1'b1) begin
      fails++;
      close_out();
    end
    repeat (8) @(posedge clk_sys_i);
    sel_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk(n, {20'h0, ei});
    bus(1'b0, `MSC_OFS_CTRL, 32'h0);
    chk(r & 32'h1, 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, `MSC_OFS_STATUS, 32'h0);
    chk(r, 32'h40);
    bus(1'b0, 12'h010, 32'h0);
    chk(r, 32'h0);
    conv(1'b0, 32'sh224, 1'b1, 1'b0, 12'h221);
    bus(1'b0, `MSC_OFS_STATUS, 32'h0);
    chk(r & 32'hE8, 32'h40);
    bus(1'b0, `MSC_OFS_RES_HI, 32'h0);
    chk(r, 32'h44);
    chk(({r[7:0], 11'h000} >= 19'h44200) ? 32'h1 : 32'h0, 32'h0);
    conv(1'b1, 32'shFFFFF060, 1'b0, 1'b1, 12'h28F);
    bus(1'b0, `MSC_OFS_STATUS, 32'h0);
    chk(r, 32'hC8);
    bus(1'b0, `MSC_OFS_RES_LO, 32'h0);
    chk(r, 32'hE3);
    bus(1'b0, `MSC_OFS_RES_HI, 32'h0);
    chk(r, 32'h54);
    bus(1'b0, `MSC_OFS_STATUS, 32'h0);
    chk(r, 32'h48);
    conv(1'b0, 32'sh0FA0, 1'b0, 1'b0, 12'h221);
    bus(1'b0, `MSC_OFS_STATUS, 32'h0);
    chk(r, 32'h40);
    bus(1'b0, `MSC_OFS_RES_LO, 32'h0);
    chk(r, 32'h1D);
    bus(1'b0, `MSC_OFS_RES_HI, 32'h0);
    chk(r, 32'hAB);
    chk(({r[7:0], 11'h000} >= 19'h44200) ? 32'h1 : 32'h0, 32'h1);
    close_out();
  end
endmodule // msc_sequencer_bench

bind msc_sequencer msc_sequencer_properties i_msc_sequencer_properties (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .zero_int_o(zero_int_o), .integ_o(integ_o),
  .deint_pos_o(deint_pos_o), .deint_neg_o(deint_neg_o), .rest_o(rest_o),
  .times_eight_phase_o(times_eight_phase_o), .eoc_o(eoc_o));
